// ---- hw/tbr_filter.sv ----
// Function
// - Make 80 MHz timebase from onboard oscillator or external reference, as configured.
// - Derive 20 MHz timebase by dividing the 80 MHz timebase.
// - Derive 100 kHz timebase by dividing 20 MHz timebase by 200.
// - Any of three timebases may source either 32-bit counter.
// - Analog in/out timing uses 20 MHz by default, 100 kHz selectable.
// - External reference selectable from eight bus lines, backplane 10 MHz, or star.
// - External reference feeds PLL; all timebases lock to it.
// - 10 MHz reference divided from onboard oscillator, drivable on any bus line.
// - Shared timebase: initiator drives 10 MHz on a line, all boards select it.
// - Bus lines bidirectional; per-line selector picks the driven internal signal.
// - Any bus line routes into analog and counter timing inputs.
// - Routed inputs have selectable polarity and edge or level sensing.
// - Enabled debounce filter samples input on each 40 MHz filter clock tick.
// - Filter passes level change only after N consecutive samples agree.
// - N is 5, 257 or about 101,800 per setting; disabled passes input.
// - Filter setting held per input; all filters disabled after reset.
// - Direct terminal-to-line or line-to-terminal routes carry the raw signal.
// - Bus lines belong to the non-isolated chassis-referenced domain.
// - Eight backplane trigger lines map one-to-one onto the eight bus lines.
`default_nettype none
package tbr_pkg;
  // Clock rates in MHz and the common divisor used for fractional dividers
  localparam int CLK_MHZ = 250;
  localparam int FAST_MHZ = 80;
  localparam int SLOW_MHZ = 20;
  localparam int REF_MHZ = 10;
  localparam int FILT_MHZ = 40;
  localparam int RATE_GCD = 10;
  localparam logic [5:0] ACC_MOD = 6'(CLK_MHZ / RATE_GCD);
  localparam logic [5:0] FAST_INC = 6'(FAST_MHZ / RATE_GCD);
  localparam logic [5:0] FILT_INC = 6'(FILT_MHZ / RATE_GCD);
  localparam logic [4:0] REF_DIV = 5'(CLK_MHZ / REF_MHZ);
  localparam logic [4:0] REF_HIGH = 5'(CLK_MHZ / REF_MHZ / 2);
  localparam logic [1:0] SLOW_DIV = 2'(FAST_MHZ / SLOW_MHZ - 1);
  localparam logic [7:0] KHZ_DIV = 8'h C7; // 200 counts of the 20 MHz tick
  // Filter sample counts
  localparam logic [16:0] FILT_N_SHORT = 17'h00005;
  localparam logic [16:0] FILT_N_MID = 17'h00101;
  localparam int FILT_N_LONG_DEF = 101800;
  // Sizes
  localparam int NUM_LINES = 8;
  localparam int NUM_FILT = 9;
  localparam int NUM_DEST = 24;
  localparam int NUM_SRC = 24;
  localparam int CTR_STRIDE = 7;
  localparam int DEST_CTR0_SRC = 10;
  // Selector codes
  localparam logic [3:0] EXT_CLK10 = 4'h8;
  localparam logic [3:0] EXT_STAR = 4'h9;
  localparam logic [3:0] ROUTE_STAR = 4'h8;
  // Register byte offsets
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_OUT_EN = 12'h008;
  localparam logic [11:0] A_FILTER = 12'h00C;
  localparam logic [11:0] A_OUT_SEL0 = 12'h010;
  localparam logic [11:0] A_OUT_SEL7 = 12'h02C;
  localparam logic [11:0] A_ROUTE0 = 12'h040;
  localparam logic [11:0] A_ROUTE23 = 12'h09C;
  // Control field positions
  localparam int C_EXT = 0;
  localparam int C_REFSEL = 1;
  localparam int C_AI_SLOW = 5;
  localparam int C_AO_SLOW = 6;
  localparam int C_CTR0 = 8;
  localparam int C_CTR1 = 10;
  localparam int R_INV = 4;
  localparam int R_EDGE = 5;
  // Reset values
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [17:0] FILTER_RST = 18'h00000;
  localparam logic [5:0] ROUTE_RST = 6'h0F;
  localparam logic [4:0] OUT_SEL_RST = 5'h00;

  typedef enum logic [1:0] {FLT_OFF, FLT_125NS, FLT_6US, FLT_2MS} tbr_filt_e;

  // Internal timing signals offered to the bus line drivers
  typedef struct packed {
    logic ai_start;
    logic ai_ref;
    logic ai_convert;
    logic ai_sample;
    logic ai_pause;
    logic ao_sample;
    logic ao_start;
    logic ao_pause;
    logic [3:0] ctr0;
    logic [3:0] ctr1;
    logic frequency_output;
    logic [5:0] pfi_raw;
  } tbr_timing_s;

  // Timebase ticks and reference level
  typedef struct packed {
    logic tb80;
    logic tb20;
    logic tb100k;
    logic ref10;
  } tbr_tb_s;
endpackage

// Debounce filter for one synchronised input
module tbr_filter #(
  parameter logic [16:0] N_LONG = 17'h18DA8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Filter tick and setting
  input wire logic sample_en,
  input wire logic [1:0] setting,
  // Signal
  input wire logic din,
  output logic dout
);
  logic [16:0] cnt;
  logic [16:0] n_need;

  // Sample count for the chosen setting
  always_comb
  begin
    unique case (tbr_pkg::tbr_filt_e'(setting))
      tbr_pkg::FLT_125NS: n_need = tbr_pkg::FILT_N_SHORT;
      tbr_pkg::FLT_6US: n_need = tbr_pkg::FILT_N_MID;
      tbr_pkg::FLT_2MS: n_need = N_LONG;
      tbr_pkg::FLT_OFF: n_need = 17'h00001;
    endcase
  end

  // Count agreeing samples; any disagreement restarts the count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dout <= 1'b0;
      cnt <= 17'h00000;
    end
    else if (setting == 2'h0)
    begin
      dout <= din;
      cnt <= 17'h00000;
    end
    else if (sample_en)
    begin
      if (din == dout)
        cnt <= 17'h00000;
      else if (cnt + 17'h00001 >= n_need)
      begin
        dout <= din;
        cnt <= 17'h00000;
      end
      else
        cnt <= cnt + 17'h00001;
    end
  end
endmodule
`default_nettype wire

// ---- hw/tbr_top.sv ----
`default_nettype none
// Timebase generation and shared trigger bus routing
module tbr_top #(
  parameter logic [16:0] FILT_N_LONG = 17'(tbr_pkg::FILT_N_LONG_DEF)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared trigger bus pins
  input wire logic [7:0] shared_trigger_bus_in,
  output logic [7:0] shared_trigger_bus_out,
  output logic [7:0] shared_trigger_bus_oe,
  // Backplane clock and star trigger pins
  input wire logic backplane_clk10,
  input wire logic star_trigger,
  // PLL interface
  input wire logic pll_locked,
  output logic pll_ref_out,
  output logic pll_ref_ext,
  // Internal timing signals to drive out
  input wire tbr_pkg::tbr_timing_s timing,
  // Timebases and routed functions
  output tbr_pkg::tbr_tb_s tb,
  output logic [1:0] counter_source_tick,
  output logic ai_timebase_tick,
  output logic ao_timebase_tick,
  output logic filter_tick,
  output logic [23:0] routed_fn,
  output logic [7:0] shared_trigger_bus_raw
);
  // Registers
  logic [11:0] ctrl;
  logic [7:0] out_en;
  logic [17:0] filter_cfg;
  logic [4:0] out_sel [tbr_pkg::NUM_LINES];
  logic [5:0] route_cfg [tbr_pkg::NUM_DEST];
  // Pin synchronisers
  localparam int NPIN = 11;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] pin_s;
  // Timebase state
  logic [5:0] fast_acc;
  logic [5:0] filt_acc;
  logic [5:0] fast_sum;
  logic [5:0] filt_sum;
  logic [1:0] slow_cnt;
  logic [7:0] khz_cnt;
  logic [4:0] ref_cnt;
  logic div_hold;
  logic ext_ref;
  logic ext_ref_d;
  logic ext_rise;
  localparam int C_REFSEL_HI = tbr_pkg::C_REFSEL + 3;
  // Filters and routing
  logic [tbr_pkg::NUM_FILT-1:0] filt_in;
  logic [tbr_pkg::NUM_FILT-1:0] filt_out;
  logic [tbr_pkg::NUM_DEST-1:0] fn_level;
  logic [tbr_pkg::NUM_DEST-1:0] fn_prev;
  logic [tbr_pkg::NUM_SRC-1:0] src_vec;
  // Bus decode
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [31:0] rd_data;
  logic in_out_sel;
  logic in_route;
  logic [2:0] sel_idx;
  logic [4:0] route_idx;

  // Pins: bus lines are the backplane trigger lines in order, bit for bit
  assign pin_raw = {pll_locked, backplane_clk10, star_trigger, shared_trigger_bus_in};

  // Three-stage synchronisers; a new level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_s <= '0;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < NPIN; i++)
        if (sync2[i] == sync3[i])
          pin_s[i] <= sync3[i];
    end
  end

  // APB decode; the slave always answers in the first access cycle
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign in_out_sel = paddr >= tbr_pkg::A_OUT_SEL0 && paddr <= tbr_pkg::A_OUT_SEL7;
  assign in_route = paddr >= tbr_pkg::A_ROUTE0 && paddr <= tbr_pkg::A_ROUTE23;
  assign sel_idx = 3'((paddr - tbr_pkg::A_OUT_SEL0) >> 2);
  assign route_idx = 5'((paddr - tbr_pkg::A_ROUTE0) >> 2);
  assign mapped = paddr[1:0] == 2'h0 && (paddr == tbr_pkg::A_CTRL
    || paddr == tbr_pkg::A_STATUS || paddr == tbr_pkg::A_OUT_EN
    || paddr == tbr_pkg::A_FILTER || in_out_sel || in_route);

  // Read mux; the status word shows live state, not stored values
  always_comb
  begin
    rd_data = 32'h00000000;
    if (paddr == tbr_pkg::A_CTRL)
      rd_data = {20'h00000, ctrl};
    else if (paddr == tbr_pkg::A_STATUS)
      rd_data = {16'h0000, pin_s[7:0], 5'h00, ext_ref, !div_hold, pin_s[10]};
    else if (paddr == tbr_pkg::A_OUT_EN)
      rd_data = {24'h000000, out_en};
    else if (paddr == tbr_pkg::A_FILTER)
      rd_data = {14'h0000, filter_cfg};
    else if (in_out_sel)
      rd_data = {27'h0000000, out_sel[sel_idx]};
    else if (in_route)
      rd_data = {26'h0000000, route_cfg[route_idx]};
  end

  // Read data is captured in the setup cycle and held through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_setup)
      prdata <= rd_data;
  end

  // Configuration registers; filters come up disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= tbr_pkg::CTRL_RST;
      out_en <= 8'h00;
      filter_cfg <= tbr_pkg::FILTER_RST;
    end
    else if (wr_en)
    begin
      if (paddr == tbr_pkg::A_CTRL)
        ctrl <= pwdata[11:0];
      if (paddr == tbr_pkg::A_OUT_EN)
        out_en <= pwdata[7:0];
      if (paddr == tbr_pkg::A_FILTER)
        filter_cfg <= pwdata[17:0];
    end
  end

  // Per-line output selectors
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < tbr_pkg::NUM_LINES; i++)
        out_sel[i] <= tbr_pkg::OUT_SEL_RST;
    end
    else if (wr_en && in_out_sel)
      out_sel[sel_idx] <= pwdata[4:0];
  end

  // Per-function input routes; reset leaves every function unrouted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < tbr_pkg::NUM_DEST; i++)
        route_cfg[i] <= tbr_pkg::ROUTE_RST;
    end
    else if (wr_en && in_route)
      route_cfg[route_idx] <= pwdata[5:0];
  end

  // External reference selection from lines, backplane clock or star
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_ref <= 1'b0;
      ext_ref_d <= 1'b0;
    end
    else
    begin
      if (ctrl[C_REFSEL_HI:tbr_pkg::C_REFSEL] == tbr_pkg::EXT_CLK10)
        ext_ref <= pin_s[9];
      else if (ctrl[C_REFSEL_HI:tbr_pkg::C_REFSEL] == tbr_pkg::EXT_STAR)
        ext_ref <= pin_s[8];
      else if (ctrl[C_REFSEL_HI] == 1'b0)
        ext_ref <= pin_s[ctrl[C_REFSEL_HI-1:tbr_pkg::C_REFSEL]];
      else
        ext_ref <= 1'b0;
      ext_ref_d <= ext_ref;
    end
  end

  // Reference goes to the PLL; its edges re-phase the fast divider
  assign pll_ref_out = ext_ref;
  assign pll_ref_ext = ctrl[tbr_pkg::C_EXT];
  assign ext_rise = ext_ref && !ext_ref_d && ctrl[tbr_pkg::C_EXT];
  // Dividers wait for lock when following an external reference
  assign div_hold = ctrl[tbr_pkg::C_EXT] && !pin_s[10];

  assign fast_sum = fast_acc + tbr_pkg::FAST_INC;
  assign filt_sum = filt_acc + tbr_pkg::FILT_INC;

  // 80 MHz tick: fractional divider, 8 ticks every 25 clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_acc <= 6'h00;
      tb.tb80 <= 1'b0;
    end
    else if (div_hold)
    begin
      fast_acc <= 6'h00;
      tb.tb80 <= 1'b0;
    end
    // A reference edge is a wrap point, so its tick is kept rather than dropped
    else if (ext_rise)
    begin
      fast_acc <= 6'h00;
      tb.tb80 <= 1'b1;
    end
    else if (fast_sum >= tbr_pkg::ACC_MOD)
    begin
      fast_acc <= fast_sum - tbr_pkg::ACC_MOD;
      tb.tb80 <= 1'b1;
    end
    else
    begin
      fast_acc <= fast_sum;
      tb.tb80 <= 1'b0;
    end
  end

  // 20 MHz and 100 kHz ticks, cascaded so all three stay in phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_cnt <= 2'h0;
      khz_cnt <= 8'h00;
      tb.tb20 <= 1'b0;
      tb.tb100k <= 1'b0;
    end
    else if (div_hold)
    begin
      slow_cnt <= 2'h0;
      khz_cnt <= 8'h00;
      tb.tb20 <= 1'b0;
      tb.tb100k <= 1'b0;
    end
    else
    begin
      tb.tb20 <= 1'b0;
      tb.tb100k <= 1'b0;
      if (tb.tb80)
      begin
        slow_cnt <= slow_cnt + 2'h1;
        if (slow_cnt == tbr_pkg::SLOW_DIV)
        begin
          tb.tb20 <= 1'b1;
          khz_cnt <= (khz_cnt == tbr_pkg::KHZ_DIV) ? 8'h00 : khz_cnt + 8'h01;
          tb.tb100k <= khz_cnt == tbr_pkg::KHZ_DIV;
        end
      end
    end
  end

  // 10 MHz reference and 40 MHz filter tick run from the onboard clock only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_cnt <= 5'h00;
      tb.ref10 <= 1'b0;
      filt_acc <= 6'h00;
      filter_tick <= 1'b0;
    end
    else
    begin
      ref_cnt <= (ref_cnt == tbr_pkg::REF_DIV - 5'h01) ? 5'h00 : ref_cnt + 5'h01;
      tb.ref10 <= ref_cnt < tbr_pkg::REF_HIGH;
      if (filt_sum >= tbr_pkg::ACC_MOD)
      begin
        filt_acc <= filt_sum - tbr_pkg::ACC_MOD;
        filter_tick <= 1'b1;
      end
      else
      begin
        filt_acc <= filt_sum;
        filter_tick <= 1'b0;
      end
    end
  end

  // Timebase choice for analog timing and the two counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ai_timebase_tick <= 1'b0;
      ao_timebase_tick <= 1'b0;
      counter_source_tick <= 2'h0;
    end
    else
    begin
      ai_timebase_tick <= ctrl[tbr_pkg::C_AI_SLOW] ? tb.tb100k : tb.tb20;
      ao_timebase_tick <= ctrl[tbr_pkg::C_AO_SLOW] ? tb.tb100k : tb.tb20;
      for (int c = 0; c < 2; c++)
      begin
        unique case (ctrl[tbr_pkg::C_CTR0 + 2*c +: 2])
          2'h0: counter_source_tick[c] <= tb.tb80;
          2'h1: counter_source_tick[c] <= tb.tb20;
          2'h2: counter_source_tick[c] <= tb.tb100k;
          2'h3: counter_source_tick[c] <= routed_fn[tbr_pkg::DEST_CTR0_SRC
            + tbr_pkg::CTR_STRIDE*c];
        endcase
      end
    end
  end

  // Debounce filters on the eight lines and the star trigger
  assign filt_in = pin_s[8:0];
  generate
    for (genvar f = 0; f < tbr_pkg::NUM_FILT; f++)
    begin : g_filt
      tbr_filter #(
        .N_LONG(FILT_N_LONG)
      ) u_filt (
        .pclk(pclk),
        .presetn(presetn),
        .sample_en(filter_tick),
        .setting(filter_cfg[2*f +: 2]),
        .din(filt_in[f]),
        .dout(filt_out[f])
      );
    end
  endgenerate

  // Routed functions: filtered source, polarity, then edge or level
  generate
    for (genvar d = 0; d < tbr_pkg::NUM_DEST; d++)
    begin : g_route
      always_comb
      begin
        if (route_cfg[d][3:0] <= tbr_pkg::ROUTE_STAR)
          fn_level[d] = filt_out[route_cfg[d][3:0]] ^ route_cfg[d][tbr_pkg::R_INV];
        else
          fn_level[d] = 1'b0;
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          fn_prev[d] <= 1'b0;
          routed_fn[d] <= 1'b0;
        end
        else
        begin
          fn_prev[d] <= fn_level[d];
          if (route_cfg[d][tbr_pkg::R_EDGE])
            routed_fn[d] <= fn_level[d] && !fn_prev[d];
          else
            routed_fn[d] <= fn_level[d];
        end
      end
    end
  endgenerate

  // Sources for the line drivers; two clocks go out inverted
  assign src_vec = {timing.pfi_raw, timing.frequency_output, timing.ctr1, timing.ctr0,
    tb.ref10, timing.ao_pause, timing.ao_start, !timing.ao_sample, timing.ai_pause,
    timing.ai_sample, !timing.ai_convert, timing.ai_ref, timing.ai_start};

  // Line drivers; the bus sits in the chassis-referenced domain
  generate
    for (genvar l = 0; l < tbr_pkg::NUM_LINES; l++)
    begin : g_line
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          shared_trigger_bus_out[l] <= 1'b0;
          shared_trigger_bus_oe[l] <= 1'b0;
        end
        else
        begin
          shared_trigger_bus_oe[l] <= out_en[l];
          if (out_sel[l] < 5'(tbr_pkg::NUM_SRC))
            shared_trigger_bus_out[l] <= src_vec[out_sel[l]];
          else
            shared_trigger_bus_out[l] <= 1'b0;
        end
      end
    end
  endgenerate

  // Unfiltered line levels for direct routes to the terminals
  assign shared_trigger_bus_raw = pin_s[7:0];

endmodule
`default_nettype wire

// ---- verification/tbr_checker.sv ----
`default_nettype none
// Timing checks at the top ports
module tbr_checker #(
  parameter logic [16:0] FILT_N_LONG = 17'h00014
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB inputs
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Watched pins
  input wire logic pll_locked,
  input wire logic pll_ref_ext,
  input wire logic [7:0] shared_trigger_bus_oe,
  input wire tbr_pkg::tbr_tb_s tb,
  input wire logic ai_timebase_tick,
  input wire logic filter_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] gap;
  logic seen;
  logic wr_ctrl, wr_oe;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Register writes as seen on the bus
  assign wr_ctrl = psel && penable && pwrite && paddr == tbr_pkg::A_CTRL;
  assign wr_oe = psel && penable && pwrite && paddr == tbr_pkg::A_OUT_EN;
  // Cycles since the last slow tick; void in external mode, where edges re-phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap <= 12'h000;
      seen <= 1'b0;
    end
    else
    begin
      gap <= tb.tb100k ? 12'h001 : gap + 12'h001;
      seen <= (seen || tb.tb100k) && !pll_ref_ext;
    end
  end
  // Reference clock high 12 cycles, then low 13
  sequence s_ref_high;
    ##11 tb.ref10 ##1 !tb.ref10;
  endsequence
  sequence s_ref_low;
    ##12 !tb.ref10 ##1 tb.ref10;
  endsequence
  a_ref_duty: assert property ($rose(tb.ref10) |-> s_ref_high ##0 s_ref_low)
    else $error("reference duty wrong");
  a_slow_gap: assert property (tb.tb20 |=> !tb.tb20 [*8])
    else $error("mid ticks too close");
  a_khz_period: assert property (tb.tb100k && seen |-> gap == 12'h9C4)
    else $error("slow period wrong");
  a_filt_gap: assert property (filter_tick |=> !filter_tick [*5])
    else $error("filter ticks too close");
  a_ai_source: assert property (ai_timebase_tick |-> $past(tb.tb20 || tb.tb100k))
    else $error("analog tick without timebase");
  a_hold_unlocked: assert property ((pll_ref_ext && !pll_locked) [*6]
    |-> !tb.tb80 && !tb.tb20) else $error("tick while unlocked");
  a_ext_mode: assert property (wr_ctrl
    |-> ##2 pll_ref_ext == $past(pwdata[tbr_pkg::C_EXT], 2)) else $error("mode wrong");
  a_oe_follow: assert property (wr_oe
    |-> ##2 shared_trigger_bus_oe == $past(pwdata[7:0], 2)) else $error("enable wrong");
endmodule
bind tbr_top tbr_checker #(.FILT_N_LONG(FILT_N_LONG)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pll_locked, .pll_ref_ext, .shared_trigger_bus_oe, .tb,
  .ai_timebase_tick, .filter_tick);
`default_nettype wire

// ---- verification/tbr_peer.sv ----
`default_nettype none
// Peer boards and backplane on the far side of the trigger bus
module tbr_peer (
  // Clock
  input wire logic pclk,
  // Bench commands
  input wire logic [7:0] drv_val,
  input wire logic [7:0] drv_en,
  input wire logic star_val,
  // Device pins
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe,
  output logic [7:0] line,
  output logic backplane_clk10,
  output logic star_trigger
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] float_pat = 8'h55;
  // Backplane clock runs free as chassis initiator, 100 ns period, edges off pclk edges
  initial
  begin
    backplane_clk10 = 1'b0;
    #1;
    forever #50 backplane_clk10 = ~backplane_clk10;
  end
  // Released lines move every cycle so a stale level cannot pass
  always @(posedge pclk)
    float_pat <= ~float_pat;
  // Line n of the chassis is line n of the device; device drive wins
  assign line = (dev_oe & dev_out) | (~dev_oe & drv_en & drv_val)
    | (~dev_oe & ~drv_en & float_pat);
  // Shared start trigger from the controller
  assign star_trigger = star_val;
endmodule
`default_nettype wire

// ---- verification/tbr_tb.sv ----
`default_nettype none
// Bench for timebases and trigger bus routing
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pll_locked, ref_o, ref_e;
  logic bp, star, star_val, err, ft, ai_t, ao_t;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] line, bus_out, bus_oe, raw, drv_val, drv_en;
  logic [1:0] cst;
  logic [23:0] rfn;
  tbr_pkg::tbr_timing_s timing;
  tbr_pkg::tbr_tb_s tb;
  int miscompares, check_count, c80, c20, ck, cf, cai, cao, cs0, cs1, cref, crise, cedge;
  // Short long-filter count keeps the run brief
  tbr_top #(.FILT_N_LONG(17'h00014)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .shared_trigger_bus_in(line),
    .shared_trigger_bus_out(bus_out), .shared_trigger_bus_oe(bus_oe), .backplane_clk10(bp),
    .star_trigger(star), .pll_locked, .pll_ref_out(ref_o), .pll_ref_ext(ref_e), .timing, .tb,
    .counter_source_tick(cst), .ai_timebase_tick(ai_t), .ao_timebase_tick(ao_t),
    .filter_tick(ft), .routed_fn(rfn), .shared_trigger_bus_raw(raw));
  // Far side of the bus
  tbr_peer peer (.pclk, .drv_val, .drv_en, .star_val, .dev_out(bus_out), .dev_oe(bus_oe),
    .line, .backplane_clk10(bp), .star_trigger(star));
  // 250 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the slave never stretches the access phase
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    check(rd, e);
    check(err, ee);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Counts ticks over n cycles, sampled mid-cycle where outputs are settled
  task automatic measure(input int n);
    logic p;
    {c80, c20, ck, cf, cai, cao, cs0, cs1, cref, crise, cedge} = '0;
    p = ref_o;
    repeat (n)
    begin
      @(negedge pclk);
      c80 += (tb.tb80 === 1'b1);
      c20 += (tb.tb20 === 1'b1);
      ck += (tb.tb100k === 1'b1);
      cf += (ft === 1'b1);
      cai += (ai_t === 1'b1);
      cao += (ao_t === 1'b1);
      cs0 += (cst[0] === 1'b1);
      cs1 += (cst[1] === 1'b1);
      cref += (tb.ref10 === 1'b1);
      crise += (ref_o === 1'b1 && p === 1'b0);
      cedge += (rfn[3] === 1'b1);
      p = ref_o;
    end
    @(posedge pclk);
  endtask
  // Timing bits that a line-out code selects
  function automatic logic [22:0] mask(input int c);
    if (c < 8)
      return 23'h400000 >> c;
    if (c < 13)
      return 23'h007800;
    if (c < 17)
      return 23'h000780;
    if (c == 17)
      return 23'h000040;
    return 23'h000001 << (c - 18);
  endfunction
  // Hang guard, well past the expected run
  initial
  begin
    #200us;
    miscompares++;
    stop_test;
  end
  // Test sequence
  initial
  begin
    {presetn, psel, penable, pwrite, pll_locked, star_val} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    drv_val = 8'h00;
    drv_en = 8'h00;
    timing = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(tbr_pkg::A_CTRL, 32'h0, 1'b0);
    rdc(tbr_pkg::A_FILTER, 32'h0, 1'b0);
    rdc(tbr_pkg::A_ROUTE0, 32'hF, 1'b0);
    rdc(12'h0A0, 32'h0, 1'b1);
    check(rfn, 32'h0);
    $display("test reset done");
    measure(250);
    check(c80, 32'h50);
    check(c20, 32'h14);
    check(cf, 32'h28);
    check(cai, 32'h14);
    check(cs0, 32'h50);
    check(cref, 32'h78);
    wr(tbr_pkg::A_CTRL, 32'h620);
    measure(5000);
    check(ck, 32'h2);
    check(cai, 32'h2);
    check(cao, 32'h190);
    check(cs0, 32'h2);
    check(cs1, 32'h190);
    $display("test timebase done");
    wr(tbr_pkg::A_OUT_SEL0 + 12'h00C, 32'h8);
    wr(tbr_pkg::A_OUT_EN, 32'h8);
    wr(tbr_pkg::A_CTRL, 32'h7);
    tick(10);
    measure(250);
    check(c80, 32'h0);
    check(crise, 32'hA);
    check(bus_oe, 32'h8);
    pll_locked <= 1'b1;
    tick(20);
    measure(250);
    check(c80 inside {[32'h4F:32'h51]}, 32'h1);
    wr(tbr_pkg::A_OUT_EN, 32'h0);
    drv_en <= 8'hFF;
    for (int s = 0; s < 10; s += 1 + (s == 7))
    begin
      wr(tbr_pkg::A_CTRL, 32'(2 * s + 1));
      for (int v = 0; v < 2; v++)
      begin
        drv_val <= 8'(v << s);
        star_val <= (v == 1) && (s == 9);
        tick(10);
        check(ref_o, 32'(v));
      end
      drv_val <= 8'h00;
      star_val <= 1'b0;
    end
    tick(10);
    rdc(tbr_pkg::A_STATUS, 32'h3, 1'b0);
    wr(tbr_pkg::A_CTRL, 32'h11);
    measure(250);
    check(crise, 32'hA);
    wr(tbr_pkg::A_CTRL, 32'h0);
    $display("test reference done");
    wr(tbr_pkg::A_OUT_EN, 32'hFF);
    tick(2);
    check(bus_oe, 32'hFF);
    for (int c = 0; c < 25; c += 1 + (c == 7))
    begin
      wr(tbr_pkg::A_OUT_SEL0 + 12'(4 * (c % 8)), 32'(c));
      for (int v = 0; v < 2; v++)
      begin
        timing <= tbr_pkg::tbr_timing_s'(v ? mask(c) : ~mask(c));
        tick(3);
        check(bus_out[c % 8], 32'((c < 24) & (v ^ (c == 2 || c == 5))));
      end
    end
    wr(tbr_pkg::A_OUT_EN, 32'h0);
    $display("test line out done");
    for (int d = 0; d < 24; d++)
    begin
      wr(tbr_pkg::A_ROUTE0 + 12'(4 * d), 32'(d % 8));
      drv_val <= 8'(1 << (d % 8));
      tick(10);
      check(rfn[d], 32'h1);
      check(raw, 32'(1 << (d % 8)));
      drv_val <= 8'h00;
      tick(10);
      check(rfn[d], 32'h0);
    end
    wr(tbr_pkg::A_ROUTE0 + 12'h008, 32'h12);
    tick(10);
    check(rfn[2], 32'h1);
    wr(tbr_pkg::A_ROUTE0 + 12'h00C, 32'h23);
    drv_val <= 8'h08;
    measure(20);
    check(cedge, 32'h1);
    $display("test routing done");
    wr(tbr_pkg::A_FILTER, 32'h4);
    drv_val <= 8'h02;
    tick(24);
    drv_val <= 8'h00;
    tick(40);
    check(rfn[1], 32'h0);
    drv_val <= 8'h03;
    tick(10);
    check(rfn[0], 32'h1);
    check(raw[1], 32'h1);
    check(rfn[1], 32'h0);
    tick(40);
    check(rfn[1], 32'h1);
    wr(tbr_pkg::A_FILTER, 32'h8);
    drv_val <= 8'h00;
    tick(1500);
    check(rfn[1], 32'h1);
    tick(200);
    check(rfn[1], 32'h0);
    wr(tbr_pkg::A_FILTER, 32'hC);
    drv_val <= 8'h02;
    tick(100);
    check(rfn[1], 32'h0);
    tick(50);
    check(rfn[1], 32'h1);
    $display("test filter done");
    stop_test;
  end
endmodule
`default_nettype wire
